// ---- hw/seq_pkg.sv ----
/*
  constants, field layouts and state types of the calibration mode sequencer.
  assumes a 40 MHz system clock; every count of cycles is derived here.
*/
`default_nettype none
package seq_pkg;
    // clock rate and conversion timing
    localparam int CLK_MHZ = 40;
    localparam int CONV_TIME_US = 100;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
    localparam logic [11:0] CONV_LAST = 12'(CONV_CYCLES - 1);
    // values after reset
    localparam logic [7:0] COMMS_RESET = 8'h04;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // communications register fields
    localparam int CM_STAT = 7;
    localparam int RS_HI = 6;
    localparam int RS_LO = 4;
    localparam int RW_BIT = 3;
    localparam int CH_HI = 2;
    localparam int CH_LO = 0;
    // mode register fields
    localparam int MD_HI = 7;
    localparam int MD_LO = 5;
    localparam int GAIN_HI = 4;
    localparam int GAIN_LO = 2;
    localparam int FILTER_RESYNC_BIT = 0;
    // operating mode codes
    localparam logic [2:0] MD_NORMAL = 3'h0;
    localparam logic [2:0] MD_SELF = 3'h1;
    localparam logic [2:0] MD_ZSYS = 3'h2;
    localparam logic [2:0] MD_FSYS = 3'h3;
    localparam logic [2:0] MD_SOFF = 3'h4;
    // register select codes
    localparam logic [2:0] RS_COMMS = 3'h0;
    localparam logic [2:0] RS_MODE = 3'h1;
    localparam logic [2:0] RS_DATA = 3'h5;
    localparam logic [2:0] RS_ZCAL = 3'h6;
    localparam logic [2:0] RS_FCAL = 3'h7;
    // front-end input source
    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_SHORT = 2'h1;
    localparam logic [1:0] SRC_REF = 2'h2;
    // serial resync: consecutive ones that reset the interface
    localparam logic [5:0] RESYNC_LAST = 6'h1F;
    // avalon byte offsets and interrupt bits
    localparam logic [3:0] AV_STATUS = 4'h0;
    localparam logic [3:0] AV_CLEAR = 4'h4;
    localparam logic [3:0] AV_ENABLE = 4'h8;
    localparam logic [3:0] AV_STATE = 4'hC;
    localparam int EV_DATA = 0;
    localparam int EV_CSTART = 1;
    localparam int EV_CDONE = 2;
    // state machines
    typedef enum logic [1:0] {IF_COMM = 2'h0, IF_WRITE = 2'h1, IF_READ = 2'h2} ser_state_t;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'h0, CAL_ZERO = 2'h1, CAL_FULL = 2'h2, CAL_FINAL = 2'h3
    } cal_state_t;
    // index of the last bit of a serial register transfer
    function automatic logic [4:0] last_bit(input logic [2:0] rs);
        last_bit = (rs >= RS_DATA) ? 5'h17 : 5'h07;
    endfunction : last_bit
endpackage : seq_pkg
`default_nettype wire

// ---- hw/bit_sync.sv ----
/*
  two-stage synchroniser for a group of independent level inputs.
  assumes each bit is a slow level; no word coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(parameter int WIDTH = 3, parameter logic [WIDTH-1:0] IDLE = '0)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] SYNC_OUT
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second
    ////////////////////////////////////////////////////////////////////////////////
    // two flops in series
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            // start at the pins' idle level, else release shows a false edge
            meta_q <= IDLE;
            SYNC_OUT <= IDLE;
        end
        else
        begin
            meta_q <= ASYNC_IN;
            SYNC_OUT <= meta_q;
        end
    end
endmodule : bit_sync
`default_nettype wire

// ---- hw/conv_timer.sv ----
/*
  conversion period timer: one-cycle done pulse every conversion time.
  assumes restart is a same-clock pulse or level; held restart freezes it.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_timer
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // control and result
    input wire logic RESTART,
    output logic DONE
);
    logic [11:0] cnt_q; // cycles into the current conversion
    ////////////////////////////////////////////////////////////////////////////////
    // count up, wrap at the end of a conversion
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cnt_q <= 12'h000;
            DONE <= 1'b0;
        end
        else if (RESTART)
        begin
            cnt_q <= 12'h000;
            DONE <= 1'b0;
        end
        else if (cnt_q == seq_pkg::CONV_LAST)
        begin
            cnt_q <= 12'h000;
            DONE <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 12'h001;
            DONE <= 1'b0;
        end
    end
endmodule : conv_timer
`default_nettype wire

// ---- hw/cal_sequencer.sv ----
/*
  operating mode and calibration sequencer with its serial register port
  and an avalon-mm slave for interrupt status, clear, enable and state.
  assumes the serial pins come from another domain (synchronised here)
  and the front-end sample word is valid on the system clock.
*/
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cal_sequencer
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // serial port pins, host side clock
    input wire logic SCLK,
    input wire logic CS_B,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_OE,
    output logic RESULT_READY_N,
    // analog front end, same clock
    input wire logic [23:0] SAMPLE,
    output logic [2:0] CHAN_SEL,
    output logic [2:0] GAIN_SEL,
    output logic [1:0] INPUT_SRC,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic IRQ
);
    logic sclk_s, cs_b_s, din_s; // synchronised pins
    logic sclk_p; // previous synced clock
    seq_pkg::ser_state_t ser_q; // serial interface state
    seq_pkg::cal_state_t cal_q; // calibration step
    logic [4:0] cnt_q; // serial bit counter
    logic [23:0] in_sr_q; // incoming shift register
    logic [23:0] out_sr_q; // outgoing shift register
    logic [7:0] comms_q; // communications register
    logic [7:0] mode_q; // mode register
    logic [23:0] data_q; // conversion result
    logic [23:0] zcoef_q, fcoef_q; // calibration coefficients
    logic [5:0] ones_q; // consecutive ones seen
    logic [2:0] status_q, enable_q; // interrupt state
    logic conv_done; // end of a conversion
    logic sclk_rise, sclk_fall; // qualified clock edges
    logic [23:0] in_next; // shift register with the new bit
    logic [2:0] rs; // register selected for next transfer
    logic [4:0] last; // last bit index of that register
    logic resync, comm_take, wr_take, rd_end, mode_wr, cal_start, cal_fin;
    logic data_load; // normal-mode result taken
    logic [2:0] md; // operating mode field
    logic [2:0] events; // events for the status register
    ////////////////////////////////////////////////////////////////////////////////
    // pin crossing and conversion timer
    bit_sync #(.WIDTH(3), .IDLE(3'h7)) u_sync // clock high, deselected, data high
    (
        .CLK(CLK),
        .RST_B(RST_B),
        .ASYNC_IN({SCLK, CS_B, DIN}),
        .SYNC_OUT({sclk_s, cs_b_s, din_s})
    );
    // holding resync bit keeps the filter idle, any mode write restarts it
    conv_timer u_timer
    (
        .CLK(CLK),
        .RST_B(RST_B),
        .RESTART(mode_wr | mode_q[seq_pkg::FILTER_RESYNC_BIT]),
        .DONE(conv_done)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // decode of edges and transfer ends
    assign sclk_rise = sclk_s & ~sclk_p & ~cs_b_s;
    assign sclk_fall = ~sclk_s & sclk_p & ~cs_b_s;
    assign in_next = {in_sr_q[22:0], din_s};
    assign rs = comms_q[seq_pkg::RS_HI:seq_pkg::RS_LO];
    assign last = seq_pkg::last_bit(rs);
    assign md = mode_q[seq_pkg::MD_HI:seq_pkg::MD_LO];
    assign resync = sclk_rise & din_s & (ones_q == seq_pkg::RESYNC_LAST);
    assign comm_take = sclk_rise & (ser_q == seq_pkg::IF_COMM) & (cnt_q == 5'h07);
    assign wr_take = sclk_rise & (ser_q == seq_pkg::IF_WRITE) & (cnt_q == last);
    assign rd_end = sclk_rise & (ser_q == seq_pkg::IF_READ) & (cnt_q == last);
    assign mode_wr = wr_take & ~resync & (rs == seq_pkg::RS_MODE);
    // codes one to four start a calibration sequence
    assign cal_start = mode_wr & (in_next[seq_pkg::MD_HI:seq_pkg::MD_LO] != seq_pkg::MD_NORMAL)
        & (in_next[seq_pkg::MD_HI:seq_pkg::MD_LO] <= seq_pkg::MD_SOFF);
    assign cal_fin = conv_done & (cal_q == seq_pkg::CAL_FINAL) & ~mode_wr;
    assign data_load = conv_done & (cal_q == seq_pkg::CAL_IDLE) & ~mode_wr;
    assign events = {cal_fin, cal_start, data_load | cal_fin};
    // word presented for a read, left aligned for msb first
    function automatic logic [23:0] read_word(input logic [2:0] sel);
        case (sel)
            // only used at comm_take, where in_next is the comms byte just written
            seq_pkg::RS_COMMS: read_word = {RESULT_READY_N, in_next[6:0], 16'h0000};
            seq_pkg::RS_MODE: read_word = {mode_q, 16'h0000};
            seq_pkg::RS_DATA: read_word = data_q;
            seq_pkg::RS_ZCAL: read_word = zcoef_q;
            seq_pkg::RS_FCAL: read_word = fcoef_q;
            default: read_word = 24'h000000; // filter and test not kept here
        endcase
    endfunction : read_word
    ////////////////////////////////////////////////////////////////////////////////
    // serial interface: comms write, then one read or write
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sclk_p <= 1'b1;
            ser_q <= seq_pkg::IF_COMM;
            cnt_q <= 5'h00;
            in_sr_q <= 24'h000000;
            out_sr_q <= 24'h000000;
            comms_q <= seq_pkg::COMMS_RESET;
            DOUT <= 1'b0;
            DOUT_OE <= 1'b0;
        end
        else
        begin
            sclk_p <= sclk_s;
            DOUT_OE <= ~cs_b_s; // drive only while selected
            if (resync)
            begin
                ser_q <= seq_pkg::IF_COMM; // lost sequence recovery
                cnt_q <= 5'h00;
            end
            else if (cs_b_s)
                cnt_q <= 5'h00; // deselect drops a partial word
            else if (sclk_rise)
            begin
                case (ser_q)
                    seq_pkg::IF_COMM:
                    begin
                        if (cnt_q == 5'h00 && din_s)
                            cnt_q <= 5'h00; // ones before the leading zero
                        else if (comm_take)
                        begin
                            cnt_q <= 5'h00;
                            comms_q[6:0] <= in_next[6:0];
                            if (in_next[seq_pkg::RW_BIT])
                            begin
                                ser_q <= seq_pkg::IF_READ;
                                out_sr_q <= read_word(in_next[seq_pkg::RS_HI:seq_pkg::RS_LO]);
                            end
                            else if (in_next[seq_pkg::RS_HI:seq_pkg::RS_LO] != seq_pkg::RS_COMMS)
                                ser_q <= seq_pkg::IF_WRITE;
                        end
                        else
                        begin
                            cnt_q <= cnt_q + 5'h01;
                            in_sr_q <= in_next;
                        end
                    end
                    seq_pkg::IF_WRITE:
                    begin
                        in_sr_q <= in_next;
                        cnt_q <= wr_take ? 5'h00 : cnt_q + 5'h01;
                        if (wr_take)
                            ser_q <= seq_pkg::IF_COMM;
                    end
                    seq_pkg::IF_READ:
                    begin
                        cnt_q <= rd_end ? 5'h00 : cnt_q + 5'h01;
                        if (rd_end)
                            ser_q <= seq_pkg::IF_COMM;
                    end
                    default: ser_q <= seq_pkg::IF_COMM;
                endcase
            end
            else if (sclk_fall && ser_q == seq_pkg::IF_READ)
            begin
                DOUT <= out_sr_q[23]; // change on falling, host samples rising
                out_sr_q <= {out_sr_q[22:0], 1'b0};
            end
        end
    end
    // consecutive ones on rising clock edges
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            ones_q <= 6'h00;
        else if (sclk_rise)
            ones_q <= (din_s && !resync) ? ones_q + 6'h01 : 6'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // mode register: host writes, sequencer clears the mode field
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            mode_q <= seq_pkg::MODE_RESET;
        else if (mode_wr)
            mode_q <= in_next[7:0];
        else if (cal_fin)
            mode_q[seq_pkg::MD_HI:seq_pkg::MD_LO] <= seq_pkg::MD_NORMAL;
    end
    // front-end selections straight from register flops
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            CHAN_SEL <= seq_pkg::COMMS_RESET[seq_pkg::CH_HI:seq_pkg::CH_LO];
            GAIN_SEL <= 3'h0;
        end
        else
        begin
            CHAN_SEL <= comms_q[seq_pkg::CH_HI:seq_pkg::CH_LO];
            GAIN_SEL <= mode_q[seq_pkg::GAIN_HI:seq_pkg::GAIN_LO];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // calibration steps and coefficient capture
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cal_q <= seq_pkg::CAL_IDLE;
            INPUT_SRC <= seq_pkg::SRC_EXT;
            zcoef_q <= 24'h000000;
            fcoef_q <= 24'h000000;
        end
        else if (cal_start)
        begin
            case (in_next[seq_pkg::MD_HI:seq_pkg::MD_LO])
                seq_pkg::MD_SELF:
                begin
                    cal_q <= seq_pkg::CAL_ZERO;
                    INPUT_SRC <= seq_pkg::SRC_SHORT;
                end
                seq_pkg::MD_FSYS:
                begin
                    cal_q <= seq_pkg::CAL_FULL;
                    INPUT_SRC <= seq_pkg::SRC_EXT;
                end
                default:
                begin
                    cal_q <= seq_pkg::CAL_ZERO;
                    INPUT_SRC <= seq_pkg::SRC_EXT;
                end
            endcase
        end
        else if (mode_wr)
        begin
            cal_q <= seq_pkg::CAL_IDLE; // normal or unused code aborts
            INPUT_SRC <= seq_pkg::SRC_EXT;
        end
        else if (conv_done)
        begin
            case (cal_q)
                seq_pkg::CAL_ZERO:
                begin
                    zcoef_q <= SAMPLE;
                    cal_q <= (md == seq_pkg::MD_ZSYS) ? seq_pkg::CAL_FINAL : seq_pkg::CAL_FULL;
                    INPUT_SRC <= (md == seq_pkg::MD_ZSYS) ? seq_pkg::SRC_EXT
                        : seq_pkg::SRC_REF;
                end
                seq_pkg::CAL_FULL:
                begin
                    fcoef_q <= SAMPLE;
                    cal_q <= seq_pkg::CAL_FINAL; // one fresh conversion follows
                    INPUT_SRC <= seq_pkg::SRC_EXT;
                end
                seq_pkg::CAL_FINAL: cal_q <= seq_pkg::CAL_IDLE;
                default: cal_q <= seq_pkg::CAL_IDLE;
            endcase
        end
        else if (wr_take && rs == seq_pkg::RS_ZCAL)
            zcoef_q <= in_next;
        else if (wr_take && rs == seq_pkg::RS_FCAL)
            fcoef_q <= in_next;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // data register and ready pin
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            RESULT_READY_N <= 1'b1;
            data_q <= 24'h000000;
        end
        else if (cal_start)
            RESULT_READY_N <= 1'b1;
        else if (cal_fin || data_load)
        begin
            RESULT_READY_N <= 1'b0;
            data_q <= SAMPLE;
        end
        else if (rd_end && rs == seq_pkg::RS_DATA)
            RESULT_READY_N <= 1'b1; // result consumed
    end
    ////////////////////////////////////////////////////////////////////////////////
    // avalon slave: one waitrequest cycle, then answer
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end
        else
        begin
            AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
            if (AVS_READ && AVS_WAITREQUEST)
            begin
                case (AVS_ADDRESS)
                    seq_pkg::AV_STATUS: AVS_READDATA <= {29'h00000000, status_q};
                    seq_pkg::AV_ENABLE: AVS_READDATA <= {29'h00000000, enable_q};
                    seq_pkg::AV_STATE: AVS_READDATA <= {11'h000, ser_q, cal_q,
                        RESULT_READY_N, comms_q, mode_q};
                    default: AVS_READDATA <= 32'h00000000; // clear is write-only
                endcase
            end
        end
    end
    // sticky status, set wins over a clear in the same cycle
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            status_q <= 3'h0;
            enable_q <= 3'h0;
            IRQ <= 1'b0;
        end
        else
        begin
            if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == seq_pkg::AV_CLEAR)
                status_q <= (status_q & ~AVS_WRITEDATA[2:0]) | events;
            else
                status_q <= status_q | events;
            if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == seq_pkg::AV_ENABLE)
                enable_q <= AVS_WRITEDATA[2:0];
            IRQ <= |(status_q & enable_q);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence self_start_s;
        cal_start && in_next[seq_pkg::MD_HI:seq_pkg::MD_LO] == seq_pkg::MD_SELF;
    endsequence
    sequence zero_shorted_s;
        cal_q == seq_pkg::CAL_ZERO && INPUT_SRC == seq_pkg::SRC_SHORT;
    endsequence
    normal_idle_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (md == seq_pkg::MD_NORMAL) |-> (cal_q == seq_pkg::CAL_IDLE))
        else $error("sequencer busy in normal mode");
    chan_follow_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (cal_q != seq_pkg::CAL_IDLE) |-> ##1 (CHAN_SEL == $past(comms_q[2:0])))
        else $error("channel output not following select");
    self_steps_a: assert property (@(posedge CLK) disable iff (!RST_B)
        self_start_s |=> zero_shorted_s)
        else $error("self calibration zero step wrong");
    mode_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
        cal_fin |=> (md == seq_pkg::MD_NORMAL && cal_q == seq_pkg::CAL_IDLE))
        else $error("mode field not cleared after calibration");
    ready_busy_a: assert property (@(posedge CLK) disable iff (!RST_B)
        cal_start |=> RESULT_READY_N throughout (##[0:3] (cal_q != seq_pkg::CAL_IDLE)))
        else $error("ready pin low at calibration start");
    ready_done_a: assert property (@(posedge CLK) disable iff (!RST_B)
        cal_fin |=> (!RESULT_READY_N && data_q == $past(SAMPLE)))
        else $error("no fresh result after calibration");
    zsys_step_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (cal_start && in_next[7:5] == seq_pkg::MD_ZSYS)
        |=> (cal_q == seq_pkg::CAL_ZERO && INPUT_SRC == seq_pkg::SRC_EXT))
        else $error("zero system step wrong");
    fsys_step_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (cal_start && in_next[7:5] == seq_pkg::MD_FSYS)
        |=> (cal_q == seq_pkg::CAL_FULL && INPUT_SRC == seq_pkg::SRC_EXT))
        else $error("full system step wrong");
    soff_full_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (conv_done && !mode_wr && cal_q == seq_pkg::CAL_ZERO && md == seq_pkg::MD_SOFF)
        |=> (cal_q == seq_pkg::CAL_FULL && INPUT_SRC == seq_pkg::SRC_REF))
        else $error("offset full step not on reference");
    mode_path_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $changed(mode_q[7:1]) |-> $past(ser_q == seq_pkg::IF_WRITE && rs == seq_pkg::RS_MODE)
            || $past(cal_fin))
        else $error("mode register changed outside its write");
    comms_stat_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (comm_take && !resync && in_next[3] && in_next[6:4] == seq_pkg::RS_COMMS)
        |=> (out_sr_q[23] == $past(RESULT_READY_N)))
        else $error("comms read status bit differs from pin");
    start_seq_a: assert property (@(posedge CLK) disable iff (!RST_B)
        cal_start |=> (cal_q != seq_pkg::CAL_IDLE && md == $past(in_next[7:5])))
        else $error("mode write did not start sequence");
endmodule : cal_sequencer
`default_nettype wire

// ---- tb/host_model.sv ----
/* host side of the serial port: byte transfers with a 200 ns clock.
   assumes the caller waits for reset and sync latency first. */
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    // serial pins
    output logic SCLK,
    output logic CS_B,
    output logic DIN,
    input wire logic DOUT
);
    // idle: clock high and still, deselected
    initial
    begin
        SCLK = 1'b1;
        CS_B = 1'b1;
        DIN = 1'b1;
    end
    // one byte each way, msb first; data in on falling, out read on rising
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #5;
        CS_B = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            SCLK = 1'b0;
            DIN = tx[i];
            #100;
            SCLK = 1'b1;
            rx[i] = DOUT;
            #100;
        end
        // released line must not keep the last bit
        DIN = ~tx[0];
        CS_B = 1'b1;
        #200;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ---- tb/cal_sequencer_tb_top.sv ----
/* bench: every calibration code through the serial host, results on avalon.
   assumes the 4000-cycle conversion time of the design package. */
`timescale 1ns/1ps
`default_nettype none
module cal_sequencer_tb_top;
    logic clk = 1'b0;
    logic rst_b, sclk, cs_b, din, dout, dout_oe, ready_n, irq, rd, wr, wait_req;
    logic [2:0] chan, gain;
    logic [1:0] src;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, r;
    logic [7:0] rx;
    int n_errors = 0;
    int comparisons = 0;
    always #12.5 clk = ~clk;
    host_model i_host_model (.SCLK(sclk), .CS_B(cs_b), .DIN(din), .DOUT(dout));
    cal_sequencer i_cal_sequencer (.CLK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b),
        .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe), .RESULT_READY_N(ready_n), .SAMPLE(24'hA5C3E1),
        .CHAN_SEL(chan), .GAIN_SEL(gain), .INPUT_SRC(src), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask : check
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // avalon access held until waitrequest is seen low
    task automatic av(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        rd <= ~we;
        wr <= we;
        addr <= a;
        wdata <= d;
        for (k = 0; k < 100; k++)
        begin
            @(posedge clk);
            if (wait_req === 1'b0)
                break;
        end
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k == 100)
        begin
            n_errors++;
            final_report();
        end
    endtask : av
    // bounded wait for the ready pin level
    task automatic wait_rdy(input logic v);
        int k;
        for (k = 0; k < 20000 && ready_n !== v; k++)
            @(posedge clk);
        if (k == 20000)
        begin
            n_errors++;
            final_report();
        end
    endtask : wait_rdy
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_b = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        av(1'b0, seq_pkg::AV_STATE, 32'h0);
        check("state", r[16:0], 17'h10400);
        av(1'b0, 4'h2, 32'h0);
        check("unmapped", r, 32'h0);
        check("oe idle", dout_oe, 1'b0);
        $display("test reset values done");
        av(1'b1, seq_pkg::AV_ENABLE, 32'h4);
        for (int c = 1; c <= 4; c++)
        begin
            i_host_model.xfer(8'h12, rx);
            i_host_model.xfer({3'(c), 3'h5, 2'h0}, rx);
            wait_rdy(1'b1);
            repeat (2000) @(posedge clk);
            check("chan", chan, 3'h2);
            check("gain", gain, 3'h5);
            check("src", src, (c == 1) ? seq_pkg::SRC_SHORT : seq_pkg::SRC_EXT);
            if (c == 1 || c == 4)
            begin
                repeat (4000) @(posedge clk);
                check("src full", src, seq_pkg::SRC_REF);
            end
            wait_rdy(1'b0);
            repeat (2) @(posedge clk);
            check("irq", irq, 1'b1);
            av(1'b0, seq_pkg::AV_STATE, 32'h0);
            check("mode", r[7:5], seq_pkg::MD_NORMAL);
            check("state ready", r[16], 1'b0);
            av(1'b0, seq_pkg::AV_STATUS, 32'h0);
            check("status", r, 32'h7);
            av(1'b1, seq_pkg::AV_CLEAR, 32'h7);
            repeat (2) @(posedge clk);
            check("irq clear", irq, 1'b0);
            $display("test code %0d done", c);
        end
        i_host_model.xfer(8'h08, rx);
        i_host_model.xfer(8'hFF, rx);
        check("comms", rx, 8'h08);
        i_host_model.xfer(8'h18, rx);
        i_host_model.xfer(8'hFF, rx);
        check("mode read", rx, 8'h14);
        $display("test comms read done");
        final_report();
    end
endmodule : cal_sequencer_tb_top
`default_nettype wire
